// *** bdm_memory_map.sv ***
// Banked data memory map: core registers, flag register, RAM routing.
`timescale 1ns/100ps
`default_nettype none
`include "bdm_params.svh"
module bdm_memory_map (
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    // Access request from the instruction datapath
    input  wire logic                       acc_req_i,
    input  wire logic                       acc_we_i,
    input  wire logic [`BDM_OFF_W-1:0]      acc_off_i,
    input  wire logic [7:0]                 acc_wdata_i,
    input  wire logic                       clr_file_i,
    output logic                            busy_o,
    output logic [7:0]                      rd_data_o,
    output logic                            rd_valid_o,
    // ALU flag results and which flags the instruction updates
    input  wire logic                       upd_z_i,
    input  wire logic                       upd_dc_i,
    input  wire logic                       upd_c_i,
    input  wire logic                       alu_z_i,
    input  wire logic                       alu_dc_i,
    input  wire logic                       alu_c_i,
    // Reset cause events from the power control logic
    input  wire logic                       to_set_i,
    input  wire logic                       to_clr_i,
    input  wire logic                       pd_set_i,
    input  wire logic                       pd_clr_i,
    // Core register contents for the rest of the core
    output logic [7:0]                      status_o,
    output logic [`BDM_BANK_W-1:0]          bank_sel_o,
    output logic [7:0]                      working_o,
    output logic [7:0]                      pc_low_o,
    output logic                            pc_low_wr_o,
    output logic [7:0]                      pc_high_latch_o,
    output logic [7:0]                      int_ctrl_o,
    output logic [`BDM_PTR_W-1:0]           pointer0_o,
    output logic [`BDM_PTR_W-1:0]           pointer1_o,
    // Peripheral register port
    output logic                            per_rd_o,
    output logic                            per_wr_o,
    output logic [`BDM_ADDR_W-1:0]          per_addr_o,
    output logic [7:0]                      per_wdata_o,
    input  wire logic [7:0]                 per_rdata_i,
    // Program memory read port
    output logic                            pm_rd_o,
    output logic [`BDM_PM_ADDR_W-1:0]       pm_addr_o,
    input  wire logic [`BDM_PM_DATA_W-1:0]  pm_data_i
);
    import bdm_pkg::*;

    // ============================================================
    // Core register state
    logic [7:0]              pc_lo_r;
    logic                    pc_lo_wr_r;
    logic [7:0]              p0l_r;
    logic [7:0]              p0h_r;
    logic [7:0]              p1l_r;
    logic [7:0]              p1h_r;
    logic [`BDM_BANK_W-1:0]  bank_r;
    logic [7:0]              work_r;
    logic [7:0]              pc_hi_r;
    logic [7:0]              irq_ctl_r;
    logic                    st_to_r;
    logic                    st_pd_r;
    logic                    st_z_r;
    logic                    st_dc_r;
    logic                    st_c_r;
    logic                    st_z_nxt;
    logic                    st_dc_nxt;
    logic                    st_c_nxt;
    logic                    st_to_nxt;
    logic                    st_pd_nxt;

    // ============================================================
    // Sequencer and output registers
    bdm_state_type               state_r;
    bdm_state_type               state_nxt;
    logic                        ext_pm_r;
    logic [7:0]                  rd_data_r;
    logic                        rd_valid_r;
    logic                        per_wr_r;
    logic [`BDM_ADDR_W-1:0]      per_addr_r;
    logic [7:0]                  per_wdata_r;
    logic [`BDM_PM_ADDR_W-1:0]   pm_addr_r;

    // ============================================================
    // Address resolution
    wire                     take     = acc_req_i & (state_r == BDM_ST_IDLE);
    wire                     via_p0   = (acc_off_i == `BDM_OFF_IND0);
    wire                     via_p1   = (acc_off_i == `BDM_OFF_IND1);
    wire [`BDM_PTR_W-1:0]    ptr0     = {p0h_r, p0l_r};
    wire [`BDM_PTR_W-1:0]    ptr1     = {p1h_r, p1l_r};
    wire [`BDM_PTR_W-1:0]    direct_a = {4'h0, bank_r, acc_off_i};
    logic [`BDM_PTR_W-1:0]   res_addr;
    bdm_region_type          region;
    logic [`BDM_IDX_W-1:0]   ram_idx;
    wire [`BDM_OFF_W-1:0]    res_off  = res_addr[`BDM_OFF_W-1:0];
    wire [7:0]               wd       = clr_file_i ? `BDM_RST_BYTE
                                                   : acc_wdata_i;

    // Direct accesses take the bank from the selection register, and
    // offsets 0 and 1 redirect through the matching pointer pair
    assign res_addr = via_p0 ? ptr0 :
                      via_p1 ? ptr1 :
                      direct_a;

    // Region split is a 32 x 128 map over the low twelve address bits
    bdm_addr_decode u_decode (
        .addr_i   (res_addr),
        .region_o (region),
        .idx_o    (ram_idx)
    );

    // ============================================================
    // Write qualifiers by target
    wire wr_take  = take & acc_we_i;
    wire wr_core  = wr_take & (region == BDM_RG_CORE);
    wire wr_ram   = wr_take & ((region == BDM_RG_GEN) |
                               (region == BDM_RG_COMMON));
    wire wr_per   = wr_take & (region == BDM_RG_PERIPH);
    wire wr_stat  = wr_core & (res_off == `BDM_OFF_STATUS);
    // External reads wait a cycle for the peripheral or program word
    wire rd_ext   = take & ~acc_we_i & ((region == BDM_RG_PERIPH) |
                                        (region == BDM_RG_PROG));

    // ============================================================
    // RAM storage
    bdm_mem_if mem ();

    assign mem.we    = wr_ram;
    assign mem.widx  = ram_idx;
    assign mem.wdata = wd;
    assign mem.ridx  = ram_idx;

    bdm_ram u_ram (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .mem    (mem)
    );

    // ============================================================
    // Flag register next state
    always_comb begin
        st_z_nxt  = st_z_r;
        st_dc_nxt = st_dc_r;
        st_c_nxt  = st_c_r;
        // Any flag-updating or clear instruction blocks all three
        // bits, so bits it does not compute keep their old value
        if (wr_stat & ~(upd_z_i | upd_dc_i | upd_c_i | clr_file_i)) begin
            st_z_nxt  = wd[`BDM_ST_Z];
            st_dc_nxt = wd[`BDM_ST_DC];
            st_c_nxt  = wd[`BDM_ST_C];
        end
        // ALU results load just the bits they update, as the data write is blocked; the
        // ALU hands carry as not-borrow when it subtracts
        if (upd_z_i) begin
            st_z_nxt = alu_z_i;
        end
        if (upd_dc_i) begin
            st_dc_nxt = alu_dc_i;
        end
        if (upd_c_i) begin
            st_c_nxt = alu_c_i;
        end
        // A clear of any register sets the zero flag
        if (wr_take & clr_file_i) begin
            st_z_nxt = 1'b1;
        end
    end

    // Reset cause bits: hardware only, a set beats a clear
    always_comb begin
        st_to_nxt = st_to_r;
        st_pd_nxt = st_pd_r;
        if (to_clr_i) begin
            st_to_nxt = 1'b0;
        end
        if (to_set_i) begin
            st_to_nxt = 1'b1;
        end
        if (pd_clr_i) begin
            st_pd_nxt = 1'b0;
        end
        if (pd_set_i) begin
            st_pd_nxt = 1'b1;
        end
    end

    // Upper three bits not stored; software never reaches cause bits
    assign status_o = {3'h0, st_to_r, st_pd_r,
                       st_z_r, st_dc_r, st_c_r};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_to_r <= `BDM_RST_CAUSE;
            st_pd_r <= `BDM_RST_CAUSE;
            st_z_r  <= `BDM_RST_FLAG;
            st_dc_r <= `BDM_RST_FLAG;
            st_c_r  <= `BDM_RST_FLAG;
        end else begin
            st_to_r <= st_to_nxt;
            st_pd_r <= st_pd_nxt;
            st_z_r  <= st_z_nxt;
            st_dc_r <= st_dc_nxt;
            st_c_r  <= st_c_nxt;
        end
    end

    // ============================================================
    // Other core registers; a pointer aimed back at offsets 0 or 1
    // writes nothing, which stops an endless indirection loop
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_lo_r    <= `BDM_RST_BYTE;
            pc_lo_wr_r <= 1'b0;
            p0l_r      <= `BDM_RST_BYTE;
            p0h_r      <= `BDM_RST_BYTE;
            p1l_r      <= `BDM_RST_BYTE;
            p1h_r      <= `BDM_RST_BYTE;
            bank_r     <= '0;
            work_r     <= `BDM_RST_BYTE;
            pc_hi_r    <= `BDM_RST_BYTE;
            irq_ctl_r  <= `BDM_RST_BYTE;
        end else begin
            pc_lo_wr_r <= wr_core & (res_off == `BDM_OFF_PC_LO);
            if (wr_core) begin
                case (res_off)
                    `BDM_OFF_PC_LO: pc_lo_r   <= wd;
                    `BDM_OFF_P0L:   p0l_r     <= wd;
                    `BDM_OFF_P0H:   p0h_r     <= wd;
                    `BDM_OFF_P1L:   p1l_r     <= wd;
                    `BDM_OFF_P1H:   p1h_r     <= wd;
                    `BDM_OFF_BANK:  bank_r    <= wd[`BDM_BANK_W-1:0];
                    `BDM_OFF_WORK:  work_r    <= wd;
                    `BDM_OFF_PC_HI: pc_hi_r   <= wd;
                    `BDM_OFF_IRQ:   irq_ctl_r <= wd;
                    default:        pc_lo_r   <= pc_lo_r;
                endcase
            end
        end
    end

    // ============================================================
    // Core register read mux; the indirect ports read as zero when
    // a pointer points at them, and unused bank bits read as zero
    logic [7:0] core_rd;
    always_comb begin
        case (res_off)
            `BDM_OFF_PC_LO:  core_rd = pc_lo_r;
            `BDM_OFF_STATUS: core_rd = status_o;
            `BDM_OFF_P0L:    core_rd = p0l_r;
            `BDM_OFF_P0H:    core_rd = p0h_r;
            `BDM_OFF_P1L:    core_rd = p1l_r;
            `BDM_OFF_P1H:    core_rd = p1h_r;
            `BDM_OFF_BANK:   core_rd = {3'h0, bank_r};
            `BDM_OFF_WORK:   core_rd = work_r;
            `BDM_OFF_PC_HI:  core_rd = pc_hi_r;
            `BDM_OFF_IRQ:    core_rd = irq_ctl_r;
            default:         core_rd = `BDM_RST_BYTE;
        endcase
    end

    // Local read data by region; anything unimplemented gives zero
    wire [7:0] local_rd = (region == BDM_RG_CORE)   ? core_rd   :
                          (region == BDM_RG_GEN)    ? mem.rdata :
                          (region == BDM_RG_COMMON) ? mem.rdata :
                          `BDM_RST_BYTE;

    // ============================================================
    // Access sequencer
    always_comb begin
        case (state_r)
            BDM_ST_IDLE: state_nxt = rd_ext ? BDM_ST_EXT : BDM_ST_IDLE;
            BDM_ST_EXT:  state_nxt = BDM_ST_IDLE;
            default:     state_nxt = BDM_ST_IDLE;
        endcase
    end

    // Read data and external port registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r     <= BDM_ST_IDLE;
            ext_pm_r    <= 1'b0;
            rd_data_r   <= `BDM_RST_BYTE;
            rd_valid_r  <= 1'b0;
            per_wr_r    <= 1'b0;
            per_addr_r  <= '0;
            per_wdata_r <= `BDM_RST_BYTE;
            pm_addr_r   <= '0;
        end else begin
            state_r    <= state_nxt;
            rd_valid_r <= 1'b0;
            per_wr_r   <= wr_per;
            if (state_r == BDM_ST_EXT) begin
                // Program words give their low byte only
                rd_data_r  <= ext_pm_r ? pm_data_i[7:0]
                                       : per_rdata_i;
                rd_valid_r <= 1'b1;
            end else if (take & ~acc_we_i & ~rd_ext) begin
                rd_data_r  <= local_rd;
                rd_valid_r <= 1'b1;
            end
            if (take) begin
                ext_pm_r    <= (region == BDM_RG_PROG);
                per_addr_r  <= res_addr[`BDM_ADDR_W-1:0];
                per_wdata_r <= wd;
                pm_addr_r   <= res_addr[`BDM_PM_ADDR_W-1:0];
            end
        end
    end

    // ============================================================
    // Outputs; a write into program memory is simply dropped
    assign busy_o          = (state_r == BDM_ST_EXT);
    assign rd_data_o       = rd_data_r;
    assign rd_valid_o      = rd_valid_r;
    assign per_rd_o        = busy_o & ~ext_pm_r;
    assign pm_rd_o         = busy_o & ext_pm_r;
    assign per_wr_o        = per_wr_r;
    assign per_addr_o      = per_addr_r;
    assign per_wdata_o     = per_wdata_r;
    assign pm_addr_o       = pm_addr_r;
    assign bank_sel_o      = bank_r;
    assign working_o       = work_r;
    assign pc_low_o        = pc_lo_r;
    assign pc_low_wr_o     = pc_lo_wr_r;
    assign pc_high_latch_o = pc_hi_r;
    assign int_ctrl_o      = irq_ctl_r;
    assign pointer0_o      = ptr0;
    assign pointer1_o      = ptr1;

endmodule : bdm_memory_map
`default_nettype wire

// *** bdm_params.svh ***
// Constants for the banked data memory map: geometry, offsets, fields.
`ifndef BDM_PARAMS_SVH
`define BDM_PARAMS_SVH

// ============================================================
// Geometry of the data space
`define BDM_BANKS         32
`define BDM_BANK_BYTES    128
`define BDM_OFF_W         7
`define BDM_BANK_W        5
`define BDM_ADDR_W        12
`define BDM_PTR_W         16
`define BDM_PM_BIT        15
`define BDM_PM_ADDR_W     15
`define BDM_PM_DATA_W     14

// ============================================================
// In-bank region boundaries (first offset past each region)
`define BDM_CORE_END      7'h0C
`define BDM_PER_END       7'h20
`define BDM_GEN_END       7'h70

// ============================================================
// Flip-flop RAM layout: implemented general banks, then common RAM
`define BDM_GEN_BYTES     9'h050
`define BDM_GEN_BANKS     5'h04
`define BDM_COMMON_BASE   9'h140
`define BDM_COMMON_BYTES  16
`define BDM_RAM_DEPTH     336
`define BDM_IDX_W         9

// ============================================================
// Core register offsets
`define BDM_OFF_IND0      7'h00
`define BDM_OFF_IND1      7'h01
`define BDM_OFF_PC_LO     7'h02
`define BDM_OFF_STATUS    7'h03
`define BDM_OFF_P0L       7'h04
`define BDM_OFF_P0H       7'h05
`define BDM_OFF_P1L       7'h06
`define BDM_OFF_P1H       7'h07
`define BDM_OFF_BANK      7'h08
`define BDM_OFF_WORK      7'h09
`define BDM_OFF_PC_HI     7'h0A
`define BDM_OFF_IRQ       7'h0B

// ============================================================
// Flag register fields and reset values
`define BDM_ST_C          0
`define BDM_ST_DC         1
`define BDM_ST_Z          2
`define BDM_ST_PD         3
`define BDM_ST_TO         4
`define BDM_RST_BYTE      8'h00
`define BDM_RST_FLAG      1'b0
`define BDM_RST_CAUSE     1'b1

`endif

// *** bdm_pkg.sv ***
// Types shared by the banked data memory map modules.
`default_nettype none
package bdm_pkg;

    // Where a resolved data address lands
    typedef enum logic [2:0] {
        BDM_RG_NONE   = 3'h0,
        BDM_RG_CORE   = 3'h1,
        BDM_RG_PERIPH = 3'h2,
        BDM_RG_GEN    = 3'h3,
        BDM_RG_COMMON = 3'h4,
        BDM_RG_PROG   = 3'h5
    } bdm_region_type;

    // Access sequencer: idle, or waiting on an external read
    typedef enum logic [1:0] {
        BDM_ST_IDLE = 2'h0,
        BDM_ST_EXT  = 2'h1
    } bdm_state_type;

endpackage : bdm_pkg
`default_nettype wire

// *** bdm_mem_if.sv ***
// Port bundle between the map controller and its flip-flop RAM.
`timescale 1ns/100ps
`default_nettype none
`include "bdm_params.svh"
interface bdm_mem_if;
    logic                  we;
    logic [`BDM_IDX_W-1:0] widx;
    logic [7:0]            wdata;
    logic [`BDM_IDX_W-1:0] ridx;
    logic [7:0]            rdata;

    modport ctl (output we, widx, wdata, ridx, input rdata);
    modport ram (input we, widx, wdata, ridx, output rdata);
endinterface : bdm_mem_if
`default_nettype wire

// *** bdm_ram.sv ***
// Flip-flop storage for general-purpose and common RAM bytes.
`timescale 1ns/100ps
`default_nettype none
`include "bdm_params.svh"
module bdm_ram (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    bdm_mem_if.ram    mem
);
    import bdm_pkg::*;

    logic [7:0] store_r [`BDM_RAM_DEPTH];

    // ============================================================
    // Write port; bytes clear at reset so reads are never unknown
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < `BDM_RAM_DEPTH; i++) begin
                store_r[i] <= `BDM_RST_BYTE;
            end
        end else if (mem.we) begin
            store_r[mem.widx] <= mem.wdata;
        end
    end

    // Asynchronous read; the controller registers the result
    assign mem.rdata = store_r[mem.ridx];

endmodule : bdm_ram
`default_nettype wire

// *** bdm_addr_decode.sv ***
// Region decoder: 16-bit resolved address to region and RAM index.
`timescale 1ns/100ps
`default_nettype none
`include "bdm_params.svh"
module bdm_addr_decode (
    input  wire logic [`BDM_PTR_W-1:0] addr_i,
    output var  bdm_pkg::bdm_region_type region_o,
    output logic [`BDM_IDX_W-1:0]      idx_o
);
    import bdm_pkg::*;

    wire [`BDM_BANK_W-1:0] bank   = addr_i[`BDM_ADDR_W-1:`BDM_OFF_W];
    wire [`BDM_OFF_W-1:0]  offset = addr_i[`BDM_OFF_W-1:0];
    wire                   is_pm  = addr_i[`BDM_PM_BIT];
    wire                   beyond = |addr_i[`BDM_PM_BIT-1:`BDM_ADDR_W];
    wire [`BDM_OFF_W-1:0]  gen_off = offset - `BDM_PER_END;
    wire [`BDM_OFF_W-1:0]  com_off = offset - `BDM_GEN_END;

    // ============================================================
    // Region split of every bank; general offsets of banks past the RAM read as zero
    always_comb begin
        region_o = BDM_RG_NONE;
        idx_o    = '0;
        if (is_pm) begin
            region_o = BDM_RG_PROG;
        end else if (beyond) begin
            region_o = BDM_RG_NONE;
        end else if (offset < `BDM_CORE_END) begin
            region_o = BDM_RG_CORE;
        end else if (offset < `BDM_PER_END) begin
            region_o = BDM_RG_PERIPH;
        end else if (offset < `BDM_GEN_END) begin
            if (bank < `BDM_GEN_BANKS) begin
                region_o = BDM_RG_GEN;
                idx_o = `BDM_IDX_W'(`BDM_IDX_W'(bank) * `BDM_GEN_BYTES
                        + `BDM_IDX_W'(gen_off));
            end
        end else begin
            // Bank number plays no part: one shared set of bytes
            region_o = BDM_RG_COMMON;
            idx_o = `BDM_COMMON_BASE + `BDM_IDX_W'(com_off[3:0]);
        end
    end

endmodule : bdm_addr_decode
`default_nettype wire

// *** bdm_partner.sv ***
// Peripheral and program memory responder for the data memory map.
`timescale 1ns/100ps
`default_nettype none
// =====
// Responder
module bdm_partner (
    input  wire logic        clk_i,
    input  wire logic        per_rd_i,
    input  wire logic [11:0] per_addr_i,
    input  wire logic        pm_rd_i,
    input  wire logic [14:0] pm_addr_i,
    output logic      [7:0]  per_rdata_o,
    output logic      [13:0] pm_data_o
);
    logic idle_r = 1'b0;
    // Idle lines flip every cycle so stale data never passes as valid
    always_ff @(posedge clk_i) idle_r <= !idle_r;
    // Answer only while strobed: a fixed scramble of the address
    assign per_rdata_o = per_rd_i ? per_addr_i[7:0] ^ 8'hA5 : {8{idle_r}};
    assign pm_data_o = pm_rd_i ? pm_addr_i[13:0] ^ 14'h2A5A : {14{idle_r}};
endmodule : bdm_partner
`default_nettype wire

// *** bdm_monitor.sv ***
// Port-level checker for the banked data memory map.
`timescale 1ns/100ps
`default_nettype none
// =====
// Checker
module bdm_monitor (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        acc_req_i,
    input wire logic        acc_we_i,
    input wire logic [6:0]  acc_off_i,
    input wire logic [7:0]  acc_wdata_i,
    input wire logic        clr_file_i,
    input wire logic        busy_o,
    input wire logic        rd_valid_o,
    input wire logic        upd_z_i,
    input wire logic        upd_c_i,
    input wire logic        alu_z_i,
    input wire logic        alu_c_i,
    input wire logic [7:0]  status_o,
    input wire logic [4:0]  bank_sel_o,
    input wire logic        per_wr_o,
    input wire logic [11:0] per_addr_o,
    input wire logic [7:0]  working_o
);
    logic tk;
    // A request only counts while the port is free
    assign tk = acc_req_i && !busy_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    busy_pulse_a: assert property (busy_o |=> !busy_o)
        else $error("busy held too long");
    ext_answer_a: assert property (busy_o |=> rd_valid_o)
        else $error("external read unanswered");
    local_answer_a: assert property (tk && !acc_we_i &&
        acc_off_i >= 7'h20 |=> rd_valid_o && !busy_o)
        else $error("local read late");
    status_top_a: assert property (status_o[7:5] == 3'h0)
        else $error("flag top bits set");
    alu_flags_a: assert property (upd_z_i && upd_c_i |=>
        status_o[2] == $past(alu_z_i) && status_o[0] == $past(alu_c_i))
        else $error("alu flags lost");
    clear_zero_a: assert property (tk && acc_we_i && clr_file_i &&
        !upd_z_i |=> status_o[2]) else $error("clear left zero flag low");
    bank_write_a: assert property (tk && acc_we_i && acc_off_i == 7'h08
        |=> bank_sel_o == ($past(clr_file_i) ? 5'h00
        : $past(acc_wdata_i[4:0])))
        else $error("bank number not taken");
    work_write_a: assert property (tk && acc_we_i && !clr_file_i &&
        acc_off_i == 7'h09 |=> working_o == $past(acc_wdata_i))
        else $error("working register not written");
    per_write_a: assert property (tk && acc_we_i &&
        acc_off_i inside {[7'h0C:7'h1F]} |=> per_wr_o &&
        per_addr_o == {$past(bank_sel_o), $past(acc_off_i)})
        else $error("peripheral write address wrong");
endmodule : bdm_monitor
bind bdm_memory_map bdm_monitor bdm_monitor_inst (.clk_i, .rstn_i,
    .acc_req_i, .acc_we_i, .acc_off_i, .acc_wdata_i, .clr_file_i, .busy_o,
    .rd_valid_o, .upd_z_i, .upd_c_i, .alu_z_i, .alu_c_i, .status_o,
    .bank_sel_o, .per_wr_o, .per_addr_o, .working_o);
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the banked data memory map.
`timescale 1ns/100ps
`default_nettype none
// =====
// Bench
module tb;
    logic clk_i = 1'b0, rstn_i = 1'b0, busy_o, rd_valid_o, per_rd_o, pm_rd_o;
    logic acc_req_i, acc_we_i, clr_file_i, upd_z_i, upd_dc_i, upd_c_i;
    logic        alu_z_i, alu_dc_i, alu_c_i;
    logic [6:0]  acc_off_i, o;
    logic [7:0]  acc_wdata_i, rd_data_o, per_rdata_i, d, e;
    logic [7:0]  q[$];
    logic [3:0]  ev;
    logic [2:0]  a;
    logic [11:0] per_addr_o;
    logic [14:0] pm_addr_o;
    logic [13:0] pm_data_i;
    int          num_errors = 0, checks_done = 0, cyc = 0, i;
    always #4 clk_i = !clk_i;
    bdm_memory_map bdm_memory_map_inst (
        .clk_i, .rstn_i, .acc_req_i, .acc_we_i, .acc_off_i, .acc_wdata_i,
        .clr_file_i, .busy_o, .rd_data_o, .rd_valid_o, .upd_z_i, .upd_dc_i,
        .upd_c_i, .alu_z_i, .alu_dc_i, .alu_c_i, .to_set_i(ev[3]),
        .to_clr_i(ev[2]), .pd_set_i(ev[1]), .pd_clr_i(ev[0]), .status_o(),
        .bank_sel_o(), .working_o(), .pc_low_o(), .pc_low_wr_o(),
        .pc_high_latch_o(), .int_ctrl_o(), .pointer0_o(), .pointer1_o(),
        .per_rd_o, .per_wr_o(), .per_addr_o, .per_wdata_o(), .per_rdata_i,
        .pm_rd_o, .pm_addr_o, .pm_data_i);
    bdm_partner bdm_partner_inst (.clk_i, .per_rd_i(per_rd_o),
        .per_addr_i(per_addr_o), .pm_rd_i(pm_rd_o), .pm_addr_i(pm_addr_o),
        .per_rdata_o(per_rdata_i), .pm_data_o(pm_data_i));
    task finish_test;
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    // One request held for one edge; waits out the busy cycle if any
    task acc(input logic w, input logic [6:0] f, input logic [7:0] v,
             input logic c);
        @(posedge clk_i);
        #1;
        {acc_req_i, acc_we_i, acc_off_i, acc_wdata_i, clr_file_i} =
            {1'b1, w, f, v, c};
        @(posedge clk_i);
        #1;
        acc_req_i = 1'b0;
        while (busy_o === 1'b1) begin
            @(posedge clk_i);
            #1;
        end
    endtask : acc
    task wr(input logic [6:0] f, input logic [7:0] v);
        acc(1'b1, f, v, 1'b0);
    endtask : wr
    task rd(input logic [6:0] f, input logic [7:0] v);
        q.push_back(v);
        acc(1'b0, f, 8'h00, 1'b0);
    endtask : rd
    task pulse(input logic [3:0] v);
        @(posedge clk_i);
        #1;
        ev = v;
        @(posedge clk_i);
        #1;
        ev = 4'h0;
    endtask : pulse
    // Every answer pulse retires the oldest expected byte
    always @(negedge clk_i) begin
        if (rd_valid_o === 1'b1) begin
            e = q.pop_front();
            checks_done++;
            if (rd_data_o !== e) begin
                $display("mismatch at %0t: got %h exp %h", $time, rd_data_o, e);
                num_errors++;
            end
        end
    end
    // Hang guard, far above the roughly 120 cycles the run needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        {acc_req_i, acc_we_i, acc_off_i, acc_wdata_i, clr_file_i} = '0;
        {upd_z_i, upd_dc_i, upd_c_i, alu_z_i, alu_dc_i, alu_c_i, ev} = '0;
        void'($urandom(68209));
        repeat (2) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        rd(7'h03, 8'h18);
        // Each RAM bank directly, then via pointer 0 from the top bank
        for (i = 0; i < 4; i++) begin
            d = 8'($urandom);
            o = 7'h20 + 7'($urandom % 80);
            wr(7'h08, 8'(i));
            wr(o, d);
            rd(o, d);
            wr(7'h04, {i[0], o});
            wr(7'h05, 8'(i >> 1));
            wr(7'h08, 8'h1F);
            rd(7'h00, d);
            rd(o, 8'h00);
        end
        wr(7'h09, d);
        wr(7'h7F, d);
        wr(7'h08, 8'h02);
        rd(7'h7F, d);
        rd(7'h08, 8'h02);
        rd(7'h09, d);
        wr(7'h0C, d);
        rd(7'h15, 8'h15 ^ 8'hA5);
        wr(7'h06, 8'h23);
        wr(7'h07, 8'h81);
        rd(7'h01, 8'(15'h0123 ^ 15'h2A5A));
        wr(7'h03, 8'hFF);
        rd(7'h03, 8'h1F);
        wr(7'h03, 8'h03);
        acc(1'b1, 7'h03, 8'hFF, 1'b1);
        rd(7'h03, 8'h1F);
        a = 3'($urandom);
        {alu_z_i, alu_dc_i, alu_c_i} = a;
        {upd_z_i, upd_dc_i, upd_c_i} = 3'h7;
        wr(7'h03, {5'h00, ~a});
        {upd_z_i, upd_dc_i, upd_c_i} = 3'h0;
        rd(7'h03, {5'h03, a});
        pulse(4'h5);
        rd(7'h03, {5'h00, a});
        wr(7'h03, {5'h18, a});
        rd(7'h03, {5'h00, a});
        pulse(4'hF);
        rd(7'h03, {5'h03, a});
        finish_test();
    end
endmodule : tb
`default_nettype wire
